// ### rtl/fac_pkg.sv
/*
 * Shared constants and encodings of the file access command unit.
 * Assumes a 12-bit APB byte address and 32-bit data.
 */
package fac_pkg;

	localparam int N_FILES = 5;
	localparam int PROFILE_FILES = 3;

	// APB byte offsets
	localparam logic [11:0] OFF_TARGET = 12'h000;
	localparam logic [11:0] OFF_ACTION = 12'h004;
	localparam logic [11:0] OFF_TRIGGER = 12'h008;
	localparam logic [11:0] OFF_PERMIT = 12'h00C;
	localparam logic [11:0] OFF_START = 12'h010;
	localparam logic [11:0] OFF_COUNT = 12'h014;
	localparam logic [11:0] OFF_OUTCOME = 12'h018;
	localparam logic [11:0] OFF_TALLY = 12'h01C;
	localparam logic [11:0] OFF_LENGTH = 12'h020;
	localparam logic [11:0] OFF_WINDOW = 12'h100;

	// Outcome register fields
	localparam int STAT_BUSY_BIT = 4;
	localparam int STAT_OPEN_BIT = 5;
	localparam int STAT_ACQ_BIT = 6;

	// Profile image header: version byte, then balancing checksum byte
	localparam logic [7:0] PROF_VERSION = 8'h02;
	localparam int PROF_HDR_BYTES = 2;

	typedef enum logic [2:0] {
		FILE_STARTUP, FILE_PROF0, FILE_PROF1, FILE_FREE, FILE_SERIAL
	} fac_file_t;

	typedef enum logic [2:0] {
		ACT_OPEN, ACT_CLOSE, ACT_READ, ACT_WRITE, ACT_DELETE
	} fac_action_t;

	typedef enum logic [1:0] {
		PERM_READ, PERM_WRITE, PERM_RW
	} fac_perm_t;

	typedef enum logic [1:0] {
		OUT_SUCCESS, OUT_OVERFLOW, OUT_FAILURE
	} fac_outcome_t;

	localparam logic [2:0] RST_TARGET = 3'h0;
	localparam logic [2:0] RST_ACTION = 3'h0;
	localparam logic [1:0] RST_PERMIT = 2'h0;
	localparam logic [31:0] RST_WORD = 32'h00000000;

endpackage

// ### rtl/fac_ifs.sv
/*
 * Interfaces between the command engine and its file store and
 * transfer window. Assumes all parties run on one clock.
 */
`timescale 1ns/1ps

interface fac_store_if #(parameter int AW = 8);
	logic [2:0] file;
	logic [AW-1:0] addr;
	logic [7:0] rdata;
	logic we;
	logic [7:0] wdata;
	logic size_we;
	logic [AW:0] size_wdata;
	logic [AW:0] size;
	modport host(output file, addr, we, wdata, size_we, size_wdata,
		input rdata, size);
	modport store(input file, addr, we, wdata, size_we, size_wdata,
		output rdata, size);
endinterface

interface fac_win_if #(parameter int AW = 6);
	logic [AW-3:0] w_idx;
	logic w_we;
	logic [31:0] w_wdata;
	logic [31:0] w_rdata;
	logic [AW-1:0] b_idx;
	logic b_we;
	logic [7:0] b_wdata;
	logic [7:0] b_rdata;
	modport host(output w_idx, w_we, w_wdata, b_idx, b_we, b_wdata,
		input w_rdata, b_rdata);
	modport buffer(input w_idx, w_we, w_wdata, b_idx, b_we, b_wdata,
		output w_rdata, b_rdata);
endinterface

// ### rtl/fac_file_store.sv
/*
 * Byte store holding every file, with per-file length.
 * Assumes the engine never writes while reset is active.
 */
`timescale 1ns/1ps

module fac_file_store #(
	parameter int FILE_BYTES = 256
) (
	input wire logic pclk,
	input wire logic presetn,
	fac_store_if.store sp
);
	localparam int AW = $clog2(FILE_BYTES);
	localparam int NF = fac_pkg::N_FILES;
	localparam int MW = $clog2(NF * FILE_BYTES);

	logic [7:0] mem [NF * FILE_BYTES];
	logic [AW:0] size [NF];
	logic f_ok;
	logic [MW-1:0] idx;

	assign f_ok = sp.file < 3'(NF);
	assign idx = MW'(sp.file) * MW'(FILE_BYTES) + MW'(sp.addr);
	assign sp.rdata = f_ok ? mem[idx] : 8'h00;
	assign sp.size = f_ok ? size[sp.file] : '0;

	// Contents are not cleared; only the lengths say what is valid
	always_ff @(posedge pclk) begin
		if (sp.we && f_ok)
			mem[idx] <= sp.wdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NF; i++)
				size[i] <= '0;
		end else if (sp.size_we && f_ok) begin
			size[sp.file] <= sp.size_wdata;
		end
	end

endmodule // fac_file_store

// ### rtl/fac_window_buf.sv
/*
 * Transfer window: word port for the bus, byte port for the engine.
 * Assumes the two write ports are never used in the same cycle.
 */
`timescale 1ns/1ps

module fac_window_buf #(
	parameter int WIN_BYTES = 64
) (
	input wire logic pclk,
	input wire logic presetn,
	fac_win_if.buffer wp
);
	localparam int AW = $clog2(WIN_BYTES);
	localparam int NW = WIN_BYTES / 4;

	logic [31:0] word [NW];
	logic [31:0] b_word;

	assign wp.w_rdata = word[wp.w_idx];
	assign b_word = word[wp.b_idx[AW-1:2]];
	assign wp.b_rdata = b_word[8 * wp.b_idx[1:0] +: 8];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NW; i++)
				word[i] <= 32'h00000000;
		end else if (wp.b_we) begin
			word[wp.b_idx[AW-1:2]][8 * wp.b_idx[1:0] +: 8] <= wp.b_wdata;
		end else if (wp.w_we) begin
			word[wp.w_idx] <= wp.w_wdata;
		end
	end

endmodule // fac_window_buf

// ### rtl/fac_top.sv
/*
 * File access command unit: APB register file, command engine,
 * acquisition interlock and profile upload check.
 * Assumes acquisition requests come from logic on pclk.
 */
// Added by the designer: the register offsets and the APB interface to the registers.
// Overview of operation
// - Five targets: startup, profile zero, profile one, free store, serial.
// - Action selector holds open/close/read/write/delete, applied on trigger.
// - Trigger is write-only; each write while the engine is idle and acquisition is stopped runs selected action on target.
// - Transfer window is readable and writable, data passes through it.
// - Window start byte sets the file position mapped by the window.
// - Window byte count sets how many file bytes are mapped.
// - Each action reports outcome: success, overflow or failure.
// - Read or write reports the number of bytes actually moved.
// - Stored length of the selected file is readable.
// - Any open file silently refuses acquisition start.
// - Trigger is disabled while acquisition runs.
// - Closing an uploaded profile applies it, converting older versions.
// - Profiles of a newer unknown version are dropped, not applied.
// - Altered profile file is discarded and regenerated.
`timescale 1ns/1ps

module fac_top #(
	parameter int FILE_BYTES = 256,
	parameter int WIN_BYTES = 64
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic acq_start_req,
	input wire logic acq_stop_req,
	output logic acq_running,
	output logic profile_load,
	output logic [1:0] profile_slot
);
	localparam int FAW = $clog2(FILE_BYTES);
	localparam int WAW = $clog2(WIN_BYTES);

	if (FILE_BYTES < 2 || WIN_BYTES < 8 || WIN_BYTES > 256
		|| (1 << WAW) != WIN_BYTES || FILE_BYTES > 65536) begin : g_bad
		$error("fac_top: unsupported buffer or file size");
	end

	typedef enum logic [2:0] {
		ST_IDLE, ST_MOVE, ST_SCAN, ST_VERDICT, ST_PATCH
	} fac_state_t;

	fac_store_if #(.AW(FAW)) st();
	fac_win_if #(.AW(WAW)) wb();

	fac_file_store #(.FILE_BYTES(FILE_BYTES)) u_store (
		.pclk(pclk),
		.presetn(presetn),
		.sp(st)
	);

	fac_window_buf #(.WIN_BYTES(WIN_BYTES)) u_window (
		.pclk(pclk),
		.presetn(presetn),
		.wp(wb)
	);

	function automatic logic [31:0] fac_min(input logic [31:0] a,
		input logic [31:0] b);
		return (a < b) ? a : b;
	endfunction

	//////////////////////////////////////////////////////////////////////
	// Register state
	logic [2:0] target, next_target;
	fac_pkg::fac_action_t action, next_action;
	logic [1:0] permit, next_permit;
	logic [31:0] start, next_start;
	logic [31:0] count, next_count;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;

	// Engine state
	fac_state_t state, next_state;
	fac_pkg::fac_outcome_t outcome, next_outcome;
	logic [31:0] tally, next_tally;
	logic [31:0] cnt, next_cnt;
	logic [31:0] n, next_n;
	logic over, next_over;
	logic is_write, next_is_write;
	logic [2:0] cur_file, next_cur_file;
	logic [4:0] open_vec, next_open_vec;
	logic [4:0] perm_rd, next_perm_rd;
	logic [4:0] perm_wr, next_perm_wr;
	logic [4:0] dirty, next_dirty;
	logic [7:0] xsum, next_xsum;
	logic [7:0] ver, next_ver;
	logic [7:0] b1, next_b1;
	logic regen, next_regen;
	logic next_acq, next_profile_load;
	logic [1:0] next_profile_slot;

	logic busy, sel_win, addr_ok, wr_now, trig, f_ok;
	logic [31:0] rd_mux, fsize, avail, room;

	//////////////////////////////////////////////////////////////////////
	// APB decode

	assign busy = state != ST_IDLE;
	assign wr_now = psel & penable & pready & pwrite & ~pslverr;
	assign fsize = 32'(st.size);
	assign f_ok = target < 3'(fac_pkg::N_FILES);

	always_comb begin
		sel_win = paddr >= fac_pkg::OFF_WINDOW
			&& 32'(paddr) < 32'(fac_pkg::OFF_WINDOW) + 32'(WIN_BYTES);
		addr_ok = paddr[1:0] == 2'h0
			&& (sel_win || paddr <= fac_pkg::OFF_LENGTH);
		rd_mux = fac_pkg::RST_WORD;
		if (sel_win) begin
			rd_mux = wb.w_rdata;
		end else begin
			unique case (paddr)
				fac_pkg::OFF_TARGET: rd_mux = {29'h0, target};
				fac_pkg::OFF_ACTION: rd_mux = {29'h0, action};
				fac_pkg::OFF_PERMIT: rd_mux = {30'h0, permit};
				fac_pkg::OFF_START: rd_mux = start;
				fac_pkg::OFF_COUNT: rd_mux = count;
				fac_pkg::OFF_OUTCOME: begin
					rd_mux[1:0] = outcome;
					rd_mux[fac_pkg::STAT_BUSY_BIT] = busy;
					rd_mux[fac_pkg::STAT_OPEN_BIT] = |open_vec;
					rd_mux[fac_pkg::STAT_ACQ_BIT] = acq_running;
				end
				fac_pkg::OFF_TALLY: rd_mux = tally;
				fac_pkg::OFF_LENGTH: rd_mux = fsize;
				default: rd_mux = fac_pkg::RST_WORD;
			endcase
		end
	end

	// Window word port; the engine owns the window while busy
	assign wb.w_idx = paddr[WAW-1:2];
	assign wb.w_we = wr_now & sel_win & ~busy;
	assign wb.w_wdata = pwdata;

	//////////////////////////////////////////////////////////////////////
	// Bus answer and control registers

	always_comb begin
		next_pready = psel & penable & ~pready;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		next_target = target;
		next_action = action;
		next_permit = permit;
		next_start = start;
		next_count = count;
		if (psel & penable & ~pready) begin
			next_prdata = (addr_ok & ~pwrite) ? rd_mux : fac_pkg::RST_WORD;
			next_pslverr = ~addr_ok;
		end
		// Selections freeze during an action so it sees stable values
		if (wr_now && !busy) begin
			unique case (paddr)
				fac_pkg::OFF_TARGET: next_target = pwdata[2:0];
				fac_pkg::OFF_ACTION:
					next_action = fac_pkg::fac_action_t'(pwdata[2:0]);
				fac_pkg::OFF_PERMIT: next_permit = pwdata[1:0];
				fac_pkg::OFF_START: next_start = pwdata;
				fac_pkg::OFF_COUNT: next_count = pwdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= fac_pkg::RST_WORD;
			pslverr <= 1'b0;
			target <= fac_pkg::RST_TARGET;
			action <= fac_pkg::fac_action_t'(fac_pkg::RST_ACTION);
			permit <= fac_pkg::RST_PERMIT;
			start <= fac_pkg::RST_WORD;
			count <= fac_pkg::RST_WORD;
		end else begin
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			target <= next_target;
			action <= next_action;
			permit <= next_permit;
			start <= next_start;
			count <= next_count;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Command engine

	// Refused triggers leave no trace at all
	assign trig = wr_now && paddr == fac_pkg::OFF_TRIGGER
		&& !busy && !acq_running;
	assign avail = (start < fsize) ? fsize - start : 32'h00000000;
	assign room = (start < 32'(FILE_BYTES))
		? 32'(FILE_BYTES) - start : 32'h00000000;

	always_comb begin
		next_state = state;
		next_outcome = outcome;
		next_tally = tally;
		next_cnt = cnt;
		next_n = n;
		next_over = over;
		next_is_write = is_write;
		next_cur_file = cur_file;
		next_open_vec = open_vec;
		next_perm_rd = perm_rd;
		next_perm_wr = perm_wr;
		next_dirty = dirty;
		next_xsum = xsum;
		next_ver = ver;
		next_b1 = b1;
		next_regen = regen;
		next_profile_load = 1'b0;
		next_profile_slot = profile_slot;
		st.file = busy ? cur_file : target;
		st.addr = '0;
		st.we = 1'b0;
		st.wdata = 8'h00;
		st.size_we = 1'b0;
		st.size_wdata = '0;
		wb.b_idx = '0;
		wb.b_we = 1'b0;
		wb.b_wdata = 8'h00;

		// Stop wins; an open file blocks start without any flag
		next_acq = acq_running;
		if (acq_stop_req)
			next_acq = 1'b0;
		else if (acq_start_req && open_vec == 5'h00)
			next_acq = 1'b1;

		unique case (state)
			ST_IDLE: if (trig) begin
				next_cur_file = target;
				next_outcome = fac_pkg::OUT_FAILURE;
				next_tally = 32'h00000000;
				next_cnt = 32'h00000000;
				next_xsum = 8'h00;
				next_is_write = action == fac_pkg::ACT_WRITE;
				unique case (action)
					fac_pkg::ACT_OPEN:
						if (f_ok && !open_vec[target] && permit != 2'h3) begin
							next_open_vec[target] = 1'b1;
							next_perm_rd[target] =
								permit != fac_pkg::PERM_WRITE;
							next_perm_wr[target] = permit != fac_pkg::PERM_READ;
							next_dirty[target] = 1'b0;
							next_outcome = fac_pkg::OUT_SUCCESS;
						end
					fac_pkg::ACT_CLOSE:
						if (f_ok && open_vec[target]) begin
							next_open_vec[target] = 1'b0;
							if (target < 3'(fac_pkg::PROFILE_FILES)
								&& dirty[target])
								next_state = ST_SCAN;
							else
								next_outcome = fac_pkg::OUT_SUCCESS;
						end
					fac_pkg::ACT_DELETE:
						if (f_ok && !open_vec[target]) begin
							st.size_we = 1'b1;
							next_outcome = fac_pkg::OUT_SUCCESS;
						end
					fac_pkg::ACT_READ, fac_pkg::ACT_WRITE: begin
						if (f_ok && open_vec[target]
							&& (next_is_write ? perm_wr[target]
							: perm_rd[target])) begin
							next_over = count > 32'(WIN_BYTES)
								|| (next_is_write && count > room);
							next_n = fac_min(fac_min(count, 32'(WIN_BYTES)),
								next_is_write ? room : avail);
							if (next_is_write)
								next_dirty[target] = 1'b1;
							if (next_n == 32'h00000000)
								next_outcome = next_over
									? fac_pkg::OUT_OVERFLOW
									: fac_pkg::OUT_SUCCESS;
							else
								next_state = ST_MOVE;
						end
					end
					default: ;
				endcase
			end
			ST_MOVE: begin
				st.addr = FAW'(start + cnt);
				wb.b_idx = WAW'(cnt);
				if (is_write) begin
					st.we = 1'b1;
					st.wdata = wb.b_rdata;
				end else begin
					wb.b_we = 1'b1;
					wb.b_wdata = st.rdata;
				end
				next_cnt = cnt + 32'h00000001;
				if (cnt == n - 32'h00000001) begin
					next_state = ST_IDLE;
					next_tally = n;
					next_outcome = over ? fac_pkg::OUT_OVERFLOW
						: fac_pkg::OUT_SUCCESS;
					if (is_write && start + n > fsize) begin
						st.size_we = 1'b1;
						st.size_wdata = (FAW + 1)'(start + n);
					end
				end
			end
			ST_SCAN: begin
				st.addr = FAW'(cnt);
				if (cnt >= fsize) begin
					next_state = ST_VERDICT;
				end else begin
					next_xsum = xsum ^ st.rdata;
					if (cnt == 32'h00000000)
						next_ver = st.rdata;
					if (cnt == 32'h00000001)
						next_b1 = st.rdata;
					next_cnt = cnt + 32'h00000001;
				end
			end
			ST_VERDICT: begin
				next_cnt = 32'h00000000;
				next_outcome = fac_pkg::OUT_SUCCESS;
				next_regen = 1'b0;
				if (fsize < 32'(fac_pkg::PROF_HDR_BYTES) || xsum != 8'h00) begin
					next_regen = 1'b1;
					next_state = ST_PATCH;
				end else if (ver == fac_pkg::PROF_VERSION) begin
					next_state = ST_IDLE;
					next_profile_load = 1'b1;
					next_profile_slot = cur_file[1:0];
				end else if (ver < fac_pkg::PROF_VERSION) begin
					next_state = ST_PATCH;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_PATCH: begin
				// Rewrite the header so the XOR of all bytes stays balanced
				st.addr = FAW'(cnt);
				st.we = 1'b1;
				st.wdata = fac_pkg::PROF_VERSION;
				if (cnt != 32'h00000000 && !regen)
					st.wdata = b1 ^ ver ^ fac_pkg::PROF_VERSION;
				next_cnt = cnt + 32'h00000001;
				if (cnt != 32'h00000000) begin
					next_state = ST_IDLE;
					if (regen) begin
						st.size_we = 1'b1;
						st.size_wdata = (FAW + 1)'(fac_pkg::PROF_HDR_BYTES);
					end else begin
						next_profile_load = 1'b1;
						next_profile_slot = cur_file[1:0];
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			outcome <= fac_pkg::OUT_SUCCESS;
			tally <= fac_pkg::RST_WORD;
			cnt <= fac_pkg::RST_WORD;
			n <= fac_pkg::RST_WORD;
			over <= 1'b0;
			is_write <= 1'b0;
			cur_file <= fac_pkg::RST_TARGET;
			open_vec <= 5'h00;
			perm_rd <= 5'h00;
			perm_wr <= 5'h00;
			dirty <= 5'h00;
			xsum <= 8'h00;
			ver <= 8'h00;
			b1 <= 8'h00;
			regen <= 1'b0;
			acq_running <= 1'b0;
			profile_load <= 1'b0;
			profile_slot <= 2'h0;
		end else begin
			state <= next_state;
			outcome <= next_outcome;
			tally <= next_tally;
			cnt <= next_cnt;
			n <= next_n;
			over <= next_over;
			is_write <= next_is_write;
			cur_file <= next_cur_file;
			open_vec <= next_open_vec;
			perm_rd <= next_perm_rd;
			perm_wr <= next_perm_wr;
			dirty <= next_dirty;
			xsum <= next_xsum;
			ver <= next_ver;
			b1 <= next_b1;
			regen <= next_regen;
			acq_running <= next_acq;
			profile_load <= next_profile_load;
			profile_slot <= next_profile_slot;
		end
	end

endmodule // fac_top

// ### tb/fac_top_props.sv
/*
 * Checker bound to fac_top: APB timing, outcome codes and pulses.
 * Assumes a master that keeps the APB transfer rules.
 */
`timescale 1ns/1ps

module fac_top_props #(
	parameter int FILE_BYTES = 256,
	parameter int WIN_BYTES = 64
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic acq_start_req,
	input wire logic acq_stop_req,
	input wire logic acq_running,
	input wire logic profile_load,
	input wire logic [1:0] profile_slot
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd_acc;
	assign rd_acc = psel && penable && pready && !pwrite;
	////////////////////////////////////////////////////////////////////
	a_one_wait_state: assert property (psel && !penable ##1 psel && penable
		|-> !pready ##1 pready) else $error("pready not in 2nd access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than a cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad refused transfer");
	a_trigger_reads_zero: assert property (rd_acc &&
		paddr == fac_pkg::OFF_TRIGGER |-> prdata == 32'h0)
		else $error("trigger readable");
	a_outcome_code: assert property (rd_acc &&
		paddr == fac_pkg::OFF_OUTCOME |-> prdata[1:0] != 2'h3)
		else $error("outcome code out of range");
	a_tally_bound: assert property (rd_acc &&
		paddr == fac_pkg::OFF_TALLY |-> prdata <= WIN_BYTES)
		else $error("tally beyond window");
	a_length_bound: assert property (rd_acc &&
		paddr == fac_pkg::OFF_LENGTH |-> prdata <= FILE_BYTES)
		else $error("length beyond store");
	a_acq_stops: assert property (acq_stop_req |=> !acq_running)
		else $error("acquisition not stopped");
	a_load_pulse: assert property (profile_load |=> !profile_load)
		else $error("load longer than a cycle");
	a_load_slot: assert property (profile_load |-> profile_slot < 2'h3)
		else $error("load slot out of range");
	c_load: cover property (profile_load);
	c_refused: cover property (pslverr);
	c_acq: cover property ($rose(acq_running));
	c_full: cover property (rd_acc && paddr == fac_pkg::OFF_TALLY &&
		prdata == WIN_BYTES);
endmodule // fac_top_props

bind fac_top fac_top_props #(.FILE_BYTES(FILE_BYTES),
	.WIN_BYTES(WIN_BYTES)) chk_u (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .acq_start_req(acq_start_req),
	.acq_stop_req(acq_stop_req), .acq_running(acq_running),
	.profile_load(profile_load), .profile_slot(profile_slot));

// ### tb/fac_host_model.sv
/*
 * Host side model: APB master issuing one transfer per task call.
 * Assumes the caller waits for each call to return.
 */
`timescale 1ns/1ps

module fac_host_model (
	input wire logic pclk,
	output logic [11:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
	end

	// Only way the host reaches the store; no raw pokes elsewhere
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No assumed latency; the bench watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Stale address and data must not look valid after release
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // fac_host_model

// ### tb/tb_file_access_command_unit.sv
/*
 * Self-checking bench for fac_top: file actions, interlock, profiles.
 * Assumes fac_host_model as the only bus master.
 */
`timescale 1ns/1ps

module tb_file_access_command_unit;
	logic pclk, presetn, acq_start_req, acq_stop_req;
	logic [11:0] paddr;
	logic psel, penable, pwrite, pready, pslverr;
	logic [31:0] pwdata, prdata, r, seed;
	logic acq_running, profile_load, e;
	logic [1:0] profile_slot;
	logic [7:0] exp_b [64];
	int err_total, n_compared, loads, t, i, s, n;
	logic [15:0] pairs [4] = '{16'h0202, 16'h0303, 16'h0002, 16'h0101};
	logic ld_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

	fac_top #(.FILE_BYTES(256), .WIN_BYTES(64)) dut_u (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acq_start_req(acq_start_req),
		.acq_stop_req(acq_stop_req), .acq_running(acq_running),
		.profile_load(profile_load), .profile_slot(profile_slot));
	fac_host_model host_u (.pclk(pclk), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) if (profile_load === 1'b1) loads++;
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, g, x);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		host_u.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		host_u.xfer(1'b0, a, 32'h0, q, e);
	endtask
	task automatic act(input logic [2:0] a);
		int k;
		logic [31:0] q;
		wr(fac_pkg::OFF_ACTION, {29'h0, a});
		wr(fac_pkg::OFF_TRIGGER, 32'h0);
		k = 0;
		do begin
			rd(fac_pkg::OFF_OUTCOME, q);
			k++;
		end while (q[4] !== 1'b0 && k < 300);
		chk({31'h0, q[4]}, 32'h0);
	endtask
	task automatic pulse_acq(input logic stop);
		@(posedge pclk);
		if (stop) acq_stop_req <= 1'b1;
		else acq_start_req <= 1'b1;
		@(posedge pclk);
		acq_start_req <= 1'b0;
		acq_stop_req <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge pclk);
		err_total++;
		tally_and_finish();
	end

	initial begin
		seed = 32'd48322;
		presetn = 1'b0;
		acq_start_req = 1'b0;
		acq_stop_req = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(fac_pkg::OFF_OUTCOME, r);
		chk(r, 32'h0);
		host_u.xfer(1'b0, 12'h040, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		rd(fac_pkg::OFF_TRIGGER, r);
		chk(r, 32'h0);
		for (t = 0; t < 5; t++) begin
			wr(fac_pkg::OFF_TARGET, t);
			wr(fac_pkg::OFF_PERMIT, fac_pkg::PERM_RW);
			act(fac_pkg::ACT_OPEN);
			rd(fac_pkg::OFF_OUTCOME, r);
			chk(r, 32'h20);
			act(fac_pkg::ACT_CLOSE);
			rd(fac_pkg::OFF_OUTCOME, r);
			chk(r, 32'h0);
		end
		wr(fac_pkg::OFF_TARGET, fac_pkg::FILE_FREE);
		wr(fac_pkg::OFF_COUNT, 32'h4);
		act(fac_pkg::ACT_READ);
		rd(fac_pkg::OFF_OUTCOME, r);
		chk(r, 32'h2);
		rd(fac_pkg::OFF_TALLY, r);
		chk(r, 32'h0);
		act(fac_pkg::ACT_DELETE);
		rd(fac_pkg::OFF_LENGTH, r);
		chk(r, 32'h0);
		wr(fac_pkg::OFF_PERMIT, fac_pkg::PERM_READ);
		act(fac_pkg::ACT_OPEN);
		act(fac_pkg::ACT_WRITE);
		rd(fac_pkg::OFF_OUTCOME, r);
		chk(r, 32'h22);
		act(fac_pkg::ACT_CLOSE);
		wr(fac_pkg::OFF_PERMIT, fac_pkg::PERM_WRITE);
		act(fac_pkg::ACT_OPEN);
		act(fac_pkg::ACT_READ);
		rd(fac_pkg::OFF_OUTCOME, r);
		chk(r, 32'h22);
		act(fac_pkg::ACT_CLOSE);
		wr(fac_pkg::OFF_PERMIT, fac_pkg::PERM_RW);
		act(fac_pkg::ACT_OPEN);
		s = xs() % 33;
		n = 1 + xs() % 64;
		for (i = 0; i < 16; i++) begin
			r = xs();
			{exp_b[4*i+3], exp_b[4*i+2], exp_b[4*i+1], exp_b[4*i]} = r;
			wr(fac_pkg::OFF_WINDOW + 12'(4 * i), r);
		end
		wr(fac_pkg::OFF_START, s);
		wr(fac_pkg::OFF_COUNT, n);
		act(fac_pkg::ACT_WRITE);
		rd(fac_pkg::OFF_TALLY, r);
		chk(r, n);
		rd(fac_pkg::OFF_LENGTH, r);
		chk(r, s + n);
		for (i = 0; i < 16; i++) wr(fac_pkg::OFF_WINDOW + 12'(4 * i), 32'h0);
		act(fac_pkg::ACT_READ);
		for (i = 0; i < n; i++) begin
			rd(fac_pkg::OFF_WINDOW + 12'(i & 60), r);
			chk({24'h0, r[8*(i%4)+:8]}, {24'h0, exp_b[i]});
		end
		wr(fac_pkg::OFF_START, 32'h0);
		wr(fac_pkg::OFF_COUNT, 32'd65);
		act(fac_pkg::ACT_READ);
		rd(fac_pkg::OFF_OUTCOME, r);
		chk(r, 32'h21);
		rd(fac_pkg::OFF_TALLY, r);
		chk(r, (s + n > 64) ? 64 : s + n);
		pulse_acq(1'b0);
		chk({31'h0, acq_running}, 32'h0);
		act(fac_pkg::ACT_CLOSE);
		pulse_acq(1'b0);
		chk({31'h0, acq_running}, 32'h1);
		wr(fac_pkg::OFF_ACTION, fac_pkg::ACT_OPEN);
		wr(fac_pkg::OFF_TRIGGER, 32'h0);
		rd(fac_pkg::OFF_OUTCOME, r);
		chk(r, 32'h40);
		pulse_acq(1'b1);
		wr(fac_pkg::OFF_TARGET, fac_pkg::FILE_PROF0);
		for (t = 0; t < 4; t++) begin
			act(fac_pkg::ACT_OPEN);
			wr(fac_pkg::OFF_WINDOW, {16'h0, pairs[t]});
			wr(fac_pkg::OFF_COUNT, 32'h2);
			act(fac_pkg::ACT_WRITE);
			i = loads;
			act(fac_pkg::ACT_CLOSE);
			chk(loads - i, ld_exp[t]);
		end
		rd(fac_pkg::OFF_LENGTH, r);
		chk(r, 32'h2);
		chk({30'h0, profile_slot}, 32'h1);
		tally_and_finish();
	end
endmodule // tb_file_access_command_unit
